// ===== acs_adc_setup.v
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "acs_defines.vh"
// Contract
// - clock code picks 151/285/545 state conversion
// - mode code single/multi/scan, 01 prohibited
// - reserved bits 3:2 read zero
// - single mode channel field picks one input
// - group modes select inputs zero upward
// - run bit self-clears except scan mode
// - group channels converted in ascending order
// - later group conversions take 128/256/512
module acs_adc_setup (
    input wire clock,
    input wire sys_rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg [3:0] chan_active,
    output reg conv_done,
    output reg bad_setting
);

// ----------------------------------------
// Helper functions
// ----------------------------------------
// First conversion length, in states
function [`ACS_CNT_W-1:0] first_len;
    input [1:0] cks;
    begin
        case (cks)
            `ACS_CKS_DIV4: first_len = `ACS_CONV_DIV4;
            `ACS_CKS_DIV8: first_len = `ACS_CONV_DIV8;
            default: first_len = `ACS_CONV_DIV16;
        endcase
    end
endfunction

// Later conversions in group modes are fixed length
function [`ACS_CNT_W-1:0] next_len;
    input [1:0] cks;
    begin
        case (cks)
            `ACS_CKS_DIV4: next_len = `ACS_NEXT_DIV4;
            `ACS_CKS_DIV8: next_len = `ACS_NEXT_DIV8;
            default: next_len = `ACS_NEXT_DIV16;
        endcase
    end
endfunction

// Group modes begin at input 0; single mode and the prohibited code at the field
function [1:0] start_chan;
    input [1:0] mode;
    input [1:0] ch;
    begin
        if ((mode == `ACS_MODE_MULTI) || (mode == `ACS_MODE_SCAN))
            start_chan = 2'b00;
        else
            start_chan = ch;
    end
endfunction

// One-hot input select; bit n drives analog input n
function [3:0] chan_onehot;
    input [1:0] ch;
    begin
        case (ch)
            2'b00: chan_onehot = 4'b0001;
            2'b01: chan_onehot = 4'b0010;
            2'b10: chan_onehot = 4'b0100;
            default: chan_onehot = 4'b1000;
        endcase
    end
endfunction

// Control word as software reads it; reserved bits are tied to zero
function [31:0] csr_pack;
    input end_flag;
    input ie;
    input run;
    input dma;
    input [1:0] cks;
    input [1:0] mode;
    input [1:0] ch;
    begin
        csr_pack = {16'h0000, end_flag, ie, run, dma, 4'h0, cks, mode, 2'b00, ch};
    end
endfunction

// ----------------------------------------
// Register state
// ----------------------------------------
reg [1:0] conv_clock_select;
reg [1:0] op_mode_select;
reg [1:0] channel_select;
reg conversion_run;
reg conv_end;
reg int_enable;
reg dma_select;
reg [1:0] cur_chan;
reg [`ACS_CNT_W-1:0] conv_cnt;
reg wr_pend;
reg [`ACS_ADDR_W-1:0] wr_addr;
// Next values from the combinational decode
reg [1:0] next_conv_clock_select;
reg [1:0] next_op_mode_select;
reg [1:0] next_channel_select;
reg next_int_enable;
reg next_dma_select;
reg next_conversion_run;
reg next_conv_end;
reg [1:0] next_cur_chan;
reg [`ACS_CNT_W-1:0] next_conv_cnt;
reg next_conv_done;
wire addr_phase;
wire [`ACS_ADDR_W-1:0] addr_lo;
wire word_access;
wire csr_write;
wire prohibited;
wire chan_done;
wire at_last;
wire end_set;
wire conv_start;

assign addr_phase = hsel & hready & htrans[1];
assign addr_lo = haddr[`ACS_ADDR_W-1:0];
// Narrow writes would only half-update a field, so they are dropped
assign word_access = (hsize == `ACS_HSIZE_WORD);
assign csr_write = wr_pend && (wr_addr == `ACS_ADDR_CSR);
// Prohibited codes are flagged, not blocked, so software can see the slip
assign prohibited = (conv_clock_select == `ACS_CKS_BAD) ||
    (op_mode_select == `ACS_MODE_BAD);
assign chan_done = conversion_run && (conv_cnt == {`ACS_CNT_W{1'b0}});
// Last channel is the field itself in every mode
assign at_last = (cur_chan == channel_select);
assign end_set = chan_done && at_last;
// Start only from idle; a run write while running does not restart
assign conv_start = csr_write && hwdata[`ACS_RUN_BIT] && !conversion_run;

// ----------------------------------------
// AHB-Lite slave: zero wait states, always OKAY
// ----------------------------------------
// Address phase is latched; the write lands at the end of its data phase
always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
        wr_pend <= 1'b0;
        wr_addr <= {`ACS_ADDR_W{1'b0}};
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end else begin
        wr_pend <= addr_phase & hwrite & word_access;
        if (addr_phase)
            wr_addr <= addr_lo;
        // Never stalls and never errors
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end
end

// Read data is loaded in the address phase and holds until the next read
always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
        hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
        // Next values, so a read right after a write sees that write
        case (addr_lo)
            `ACS_ADDR_CSR: hrdata <= csr_pack(next_conv_end, next_int_enable,
                next_conversion_run, next_dma_select, next_conv_clock_select,
                next_op_mode_select, next_channel_select);
            `ACS_ADDR_CHAN: hrdata <= {30'h00000000, next_cur_chan};
            default: hrdata <= 32'h00000000;
        endcase
    end
end

// ----------------------------------------
// Configuration fields: next values
// ----------------------------------------
// Fields follow every whole-word write to the control word; changing them mid-run is the software's risk
always @* begin
    next_conv_clock_select = conv_clock_select;
    next_op_mode_select = op_mode_select;
    next_channel_select = channel_select;
    next_int_enable = int_enable;
    next_dma_select = dma_select;
    if (csr_write) begin
        next_conv_clock_select = hwdata[`ACS_CKS_HI:`ACS_CKS_LO];
        next_op_mode_select = hwdata[`ACS_MODE_HI:`ACS_MODE_LO];
        next_channel_select = hwdata[`ACS_CH_HI:`ACS_CH_LO];
        next_int_enable = hwdata[`ACS_IE_BIT];
        next_dma_select = hwdata[`ACS_DMASL_BIT];
    end
end

// ----------------------------------------
// Sequencer: next values
// ----------------------------------------
// Hardware steps first; a software write of run then overrides self-clear
always @* begin
    next_conversion_run = conversion_run;
    next_conv_end = conv_end;
    next_cur_chan = cur_chan;
    next_conv_cnt = conv_cnt;
    next_conv_done = 1'b0;
    if (conversion_run) begin
        if (chan_done) begin
            next_conv_done = 1'b1;
            if (at_last) begin
                if (op_mode_select == `ACS_MODE_SCAN) begin
                    next_cur_chan = 2'b00;
                    next_conv_cnt = next_len(conv_clock_select) - 1'b1;
                end else begin
                    next_conversion_run = 1'b0;
                end
            end else begin
                next_cur_chan = cur_chan + 2'b01;
                next_conv_cnt = next_len(conv_clock_select) - 1'b1;
            end
        end else begin
            next_conv_cnt = conv_cnt - 1'b1;
        end
    end
    if (csr_write) begin
        // Writing run low halts at once
        next_conversion_run = hwdata[`ACS_RUN_BIT];
        // Only a zero written to the end flag clears it
        if (!hwdata[`ACS_END_BIT])
            next_conv_end = 1'b0;
    end
    // End of the last selected channel sets the flag; the set beats a clear
    if (end_set)
        next_conv_end = 1'b1;
    if (conv_start) begin
        // Fields may be written together with the start
        next_cur_chan = start_chan(hwdata[`ACS_MODE_HI:`ACS_MODE_LO],
            hwdata[`ACS_CH_HI:`ACS_CH_LO]);
        next_conv_cnt = first_len(hwdata[`ACS_CKS_HI:`ACS_CKS_LO]) - 1'b1;
    end
end

// ----------------------------------------
// Register state update
// ----------------------------------------
// Configuration fields
always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
        conv_clock_select <= `ACS_CKS_RST;
        op_mode_select <= `ACS_MODE_RST;
        channel_select <= `ACS_CH_RST;
        int_enable <= 1'b0;
        dma_select <= 1'b0;
    end else begin
        conv_clock_select <= next_conv_clock_select;
        op_mode_select <= next_op_mode_select;
        channel_select <= next_channel_select;
        int_enable <= next_int_enable;
        dma_select <= next_dma_select;
    end
end

// Sequencer state
always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
        conversion_run <= 1'b0;
        conv_end <= 1'b0;
        cur_chan <= 2'b00;
        conv_cnt <= {`ACS_CNT_W{1'b0}};
        conv_done <= 1'b0;
    end else begin
        conversion_run <= next_conversion_run;
        conv_end <= next_conv_end;
        cur_chan <= next_cur_chan;
        conv_cnt <= next_conv_cnt;
        conv_done <= next_conv_done;
    end
end

// ----------------------------------------
// Registered outputs toward the converter
// ----------------------------------------
// One-hot input select, valid only while running
always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
        chan_active <= 4'h0;
    end else begin
        chan_active <= conversion_run ? chan_onehot(cur_chan) : 4'h0;
    end
end

// Prohibited codes show one cycle after they are stored
always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
        bad_setting <= 1'b0;
    end else begin
        bad_setting <= prohibited;
    end
end

endmodule // acs_adc_setup

// ===== acs_defines.vh
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define ACS_ADDR_CSR 8'h00
`define ACS_ADDR_CHAN 8'h04
`define ACS_ADDR_W 8
// ----------------------------------------
// Control/status field positions
// ----------------------------------------
`define ACS_CH_LO 0
`define ACS_CH_HI 1
`define ACS_MODE_LO 4
`define ACS_MODE_HI 5
`define ACS_CKS_LO 6
`define ACS_CKS_HI 7
`define ACS_DMASL_BIT 12
`define ACS_RUN_BIT 13
`define ACS_IE_BIT 14
`define ACS_END_BIT 15
`define ACS_RSV_MASK 8'h0c
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACS_CKS_RST 2'b01
`define ACS_MODE_RST 2'b00
`define ACS_CH_RST 2'b00
// ----------------------------------------
// Encodings
// ----------------------------------------
`define ACS_CKS_DIV4 2'b00
`define ACS_CKS_DIV8 2'b01
`define ACS_CKS_DIV16 2'b10
`define ACS_CKS_BAD 2'b11
`define ACS_MODE_SINGLE 2'b00
`define ACS_MODE_BAD 2'b01
`define ACS_MODE_MULTI 2'b10
`define ACS_MODE_SCAN 2'b11
`define ACS_HTRANS_NONSEQ 2'b10
`define ACS_HSIZE_WORD 3'b010
// ----------------------------------------
// Timing in peripheral-clock states
// ----------------------------------------
`define ACS_CONV_DIV4 10'd151
`define ACS_CONV_DIV8 10'd285
`define ACS_CONV_DIV16 10'd545
`define ACS_NEXT_DIV4 10'd128
`define ACS_NEXT_DIV8 10'd256
`define ACS_NEXT_DIV16 10'd512
`define ACS_CNT_W 10
`endif

// ===== acs_adc_setup_chk.sv
`timescale 1ns/1ns
// -----
// Port checker
// -----
module acs_adc_setup_chk (
    input wire clock,
    input wire sys_rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire [3:0] chan_active,
    input wire conv_done,
    input wire bad_setting
);
    reg rd = 1'h0;
    reg wr = 1'h0;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Data-phase flags, so data is judged in its own cycle
    always @(posedge clock) begin
        rd <= !sys_rst && hsel && hready && htrans[1] && haddr == 32'h0 && !hwrite;
        wr <= !sys_rst && hsel && hready && htrans[1] && haddr == 32'h0 && hwrite;
    end
    chk_rsv_zero: assert property (rd |-> hrdata[3:2] == 2'h0) else $error("rsv");
    chk_bad_mode: assert property (wr && hwdata[5:4] == 2'h1 |-> ##[1:2] bad_setting)
        else $error("mode flag");
    chk_bad_clock: assert property (wr && hwdata[7:6] == 2'h3 |-> ##[1:2] bad_setting)
        else $error("clock flag");
    chk_good_set: assert property (wr && hwdata[7:6] != 2'h3
        && hwdata[5:4] != 2'h1 |-> ##2 !bad_setting) else $error("flag stuck");
    chk_one_hot: assert property ($onehot0(chan_active)) else $error("inputs");
    chk_ascend: assert property (chan_active != 0 && $past(chan_active) != 0
        && chan_active != $past(chan_active) |-> chan_active == 4'h1
        || chan_active == {$past(chan_active[2:0]), 1'h0}) else $error("order");
    chk_done_gap: assert property (conv_done |=> !conv_done [*8]) else $error("gap");
    chk_done_chan: assert property (conv_done |-> $past(chan_active) != 0) else $error("idle");
    cover property (conv_done && chan_active == 4'h8);
    cover property (wr && hwdata[5:4] == 2'h3);
    cover property (bad_setting);
endmodule // acs_adc_setup_chk
bind acs_adc_setup acs_adc_setup_chk acs_adc_setup_chk_inst (.clock, .sys_rst, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hrdata, .chan_active, .conv_done, .bad_setting);

// ===== acs_conv_model.sv
`timescale 1ns/1ns
// -----
// Converter side: logs each finished input
// -----
module acs_conv_model (
    input wire clock,
    input wire [3:0] chan_active,
    input wire conv_done
);
    int seen[$];
    int lens[$];
    int cnt = 0;
    logic [3:0] held = 4'h0;
    // Restart at each end pulse, so later inputs are timed pulse to pulse
    always @(posedge clock) begin
        if (conv_done) seen.push_back($clog2(held));
        if (conv_done) lens.push_back(cnt);
        cnt <= conv_done ? 1 : (chan_active != 4'h0 ? cnt + 1 : 0);
        if (chan_active != 4'h0) held <= chan_active;
    end
endmodule // acs_conv_model

// ===== acs_adc_setup_tb.sv
`timescale 1ns/1ns
module acs_adc_setup_tb;
    logic clock = 1'h0, sys_rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
    logic hreadyout, hresp, conv_done, bad_setting;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [3:0] chan_active;
    int fail_count = 0, checks = 0, seed = 39906, b, k, n;
    always #5 clock = ~clock;
    acs_adc_setup acs_adc_setup_inst (.clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .chan_active, .conv_done, .bad_setting);
    acs_conv_model acs_conv_model_inst (.clock, .chan_active, .conv_done);
    task automatic give_verdict;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    // Address phase, then data phase, each held until ready
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge clock);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin @(posedge clock); n++; end while (hreadyout !== 1'h1 && n < 50);
            if (hreadyout !== 1'h1) chk(0, 1, "hang");
            if (hreadyout !== 1'h1) give_verdict();
            htrans <= 2'h0;
            hwdata <= d;
        end
        chk(hresp, 1'h0, "okay response");
        r = hrdata;
    endtask
    function automatic int exp_len(int c, int j);
        return j > 0 ? 128 << c : (c == 0 ? 151 : (c == 1 ? 285 : 545));
    endfunction
    // Fields go in with run low first; changing them while running is unsafe
    task automatic conv(int c, int m, int h, int cnt);
        b = acs_conv_model_inst.seen.size();
        bus(1'h1, 32'h0, c * 64 + m * 16 + h);
        bus(1'h1, 32'h0, 32'h2000 + c * 64 + m * 16 + h);
        for (k = 0; k < 3000 && acs_conv_model_inst.seen.size() < b + cnt; k++) @(posedge clock);
        chk(k < 3000, 1, "no end");
        if (k == 3000) give_verdict();
        for (int j = 0; j < cnt; j++) begin
            chk(acs_conv_model_inst.seen[b + j], m ? j % (h + 1) : h, "order");
            // The model starts counting one cycle after the run bit, so the first is one short
            n = exp_len(c, j) - (j == 0);
            chk(acs_conv_model_inst.lens[b + j], n, "length");
        end
        if (m < 3) bus(1'h0, 32'h0, 32'h0);
        if (m < 3) chk(r[13], 1'h0, "run stuck");
        if (m < 3) chk(r[15], 1'h1, "end flag");
        if (m < 3) bus(1'h0, 32'h4, 32'h0);
        if (m < 3) chk(r, h, "last input");
    endtask
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'h0;
        bus(1'h0, 32'h0, 32'h0);
        chk(r, 32'h40, "reset value");
        bus(1'h1, 32'h0, 32'h4c);
        bus(1'h0, 32'h0, 32'h0);
        chk(r, 32'h40, "reserved");
        bus(1'h0, 32'h8, 32'h0);
        chk(r, 32'h0, "unmapped");
        for (k = 16; k < 200; k += 176) begin
            bus(1'h1, 32'h0, k);
            repeat (2) @(posedge clock);
            chk(bad_setting, 1'h1, "bad code");
        end
        for (int i = 0; i < 8; i++) conv($unsigned($random(seed)) % 3, i % 2 * 2, i / 2, i % 2 * (i / 2) + 1);
        conv(0, 3, 1, 5);
        bus(1'h1, 32'h0, 32'h31);
        repeat (3) @(posedge clock);
        chk(chan_active, 4'h0, "scan stop");
        give_verdict();
    end
endmodule // acs_adc_setup_tb
